// File: design/crosspoint_switch_control_port.sv
// Control port of an 8x8 crosspoint switch with a Wishbone window.
// Assumes pins are asynchronous to clk_i and strobes last several
// clock periods; the Wishbone master is on clk_i.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "xpt_defs.svh"

// Two-stage synchroniser for a vector of pins
module xpt_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q; // First stage, read only by second
   logic [W-1:0] sync_q; // Second stage
   // Two flops in a row
   always_ff @(posedge clk_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
   end
   assign q_o = sync_q;
endmodule

module crosspoint_switch_control_port (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic interface_select_i,
   input wire logic bit0_or_shift_input_i,
   input wire logic bit1_or_shift_output_i,
   output logic bit1_or_shift_output_o,
   output logic bit1_or_shift_output_oe_o,
   input wire logic data_bit_two_i,
   input wire logic code_class_bit_i,
   input wire logic [2:0] output_select_i,
   input wire logic write_strobe_i,
   input wire logic transfer_strobe_i,
   input wire logic chip_select_n_i,
   input wire logic chip_select_i,
   input wire logic transfer_mode_i,
   input wire logic termination_enable_i,
   output logic [7:0] buffer_enable_o,
   output logic [31:0] switch_code_o,
   output logic termination_on_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   logic [`PIN_W-1:0] pin_s; // Synchronised pins
   logic ser_s; // Serial interface chosen
   logic d0_s, d1_s, d2_s, class_s; // Data pins
   logic [2:0] addr_s; // Output select
   logic wr_s, lt_s; // Write and transfer strobes
   logic csn_s, cs_s; // Chip selects
   logic mode_s; // Edge mode when high
   logic term_s; // Termination request
   logic wr_prev_q, lt_prev_q; // Strobe history
   logic [31:0] first_q, first_d; // First rank
   logic [31:0] second_q; // Second rank
   logic [7:0] en_q, en_d; // Buffer enables
   logic ctrl_q; // Software accept of write strobes
   logic sout_q, oe_q, term_q; // Pin side flops
   logic [31:0] wb_dat_q; // Read data
   logic wb_ack_q; // Bus answer
   logic wr_rise, lt_rise, cs_ok, wr_ok;
   logic ser_wr, par_wr, par_store, par_ctl, par_sw, load_now;
   logic [3:0] cmd_w; // Parallel command nibble
   logic [7:0] addr_mask; // One-hot addressed output
   logic [31:0] nib_mask; // Nibble of addressed output
   logic [31:0] xfer_second; // Rank two after a load
   logic [7:0] xfer_en; // Enables after a load
   logic wb_req, wb_wr, ctrl_hit, first_hit, second_hit, stat_hit;
   logic [31:0] rd_w;

   // Every pin passes two flops before use
   xpt_sync2 #(.W(`PIN_W)) u_sync (
      .clk_i(clk_i),
      .d_i({termination_enable_i, transfer_mode_i, chip_select_i,
            chip_select_n_i, transfer_strobe_i, write_strobe_i,
            output_select_i, code_class_bit_i, data_bit_two_i,
            bit1_or_shift_output_i, bit0_or_shift_input_i,
            interface_select_i}),
      .q_o(pin_s)
   );

   // Unpack the synchronised pins
   assign ser_s = pin_s[`POS_IFSEL];
   assign d0_s = pin_s[`POS_D0];
   assign d1_s = pin_s[`POS_D1];
   assign d2_s = pin_s[`POS_D2];
   assign class_s = pin_s[`POS_CLASS];
   assign addr_s = pin_s[`POS_ADDR +: 3];
   assign wr_s = pin_s[`POS_WR];
   assign lt_s = pin_s[`POS_LT];
   assign csn_s = pin_s[`POS_CSN];
   assign cs_s = pin_s[`POS_CS];
   assign mode_s = pin_s[`POS_MODE];
   assign term_s = pin_s[`POS_TERM];

   // Strobe edges and write qualification
   assign wr_rise = wr_s & ~wr_prev_q;
   assign lt_rise = lt_s & ~lt_prev_q;
   assign cs_ok = ~csn_s & cs_s;
   assign wr_ok = wr_rise & cs_ok & ctrl_q;
   assign ser_wr = wr_ok & ser_s;
   assign par_wr = wr_ok & ~ser_s;

   // Parallel command decode; class bit picks channel or control
   assign cmd_w = {class_s, d2_s, d1_s, d0_s};
   assign par_store = par_wr & (cmd_w <= 4'h8);
   assign par_ctl = par_wr & (cmd_w >= 4'hb) & (cmd_w <= 4'he);
   assign par_sw = par_wr & lt_s
      & (cmd_w == xpt_types_pkg::CMD_SW_XFER);

   // Output addressed by the host
   assign addr_mask = 8'h01 << addr_s;
   assign nib_mask = 32'hf000_0000 >> {addr_s, 2'b00};

   // When rank two takes rank one
   assign load_now = (mode_s ? lt_rise : ~lt_s)
      | par_ctl
      | par_sw;

   // First rank: serial shift or parallel nibble store
   assign first_d = ser_wr ? {first_q[30:0], d0_s}
      : par_store ? ((first_q & ~nib_mask)
                     | ({8{cmd_w}} & nib_mask))
      : first_q;

   // Per-output load; output 0 sits in the top nibble
   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_out
         xpt_types_pkg::code_t fn; // Rank one code
         xpt_types_pkg::code_t sn; // Rank two code
         assign fn = first_q[31-4*k -: 4];
         assign sn = second_q[31-4*k -: 4];
         // Codes above 1010 inhibit the load
         assign xfer_second[31-4*k -: 4] = (fn <= 4'ha) ? fn : sn;
         // Serial on and off codes steer the buffer
         assign xfer_en[k] =
            (fn == xpt_types_pkg::CMD_SER_ON) ? 1'b1
            : (fn == xpt_types_pkg::CMD_SER_OFF) ? 1'b0
            : en_q[k];
      end
   endgenerate

   // Enables: load first, then parallel control on top
   always_comb begin
      en_d = load_now ? xfer_en : en_q;
      if (par_ctl) begin
         case (cmd_w)
            xpt_types_pkg::CMD_OFF_ONE: begin
               en_d = en_d & ~addr_mask;
            end
            xpt_types_pkg::CMD_ON_ONE: begin
               en_d = en_d | addr_mask;
            end
            xpt_types_pkg::CMD_OFF_ALL: begin
               en_d = 8'h00;
            end
            xpt_types_pkg::CMD_ON_ALL: begin
               en_d = 8'hff;
            end
            default: begin
               en_d = en_d;
            end
         endcase
      end
   end

   // Strobe history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_prev_q <= wr_s; // Track the pin level: no false edge
         lt_prev_q <= lt_s; // Strobe may idle high across reset
      end else begin
         wr_prev_q <= wr_s;
         lt_prev_q <= lt_s;
      end
   end

   // Both ranks and the buffer enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_q <= `FIRST_RST;
         second_q <= `SECOND_RST;
         en_q <= `EN_RST;
      end else begin
         first_q <= first_d;
         en_q <= en_d;
         if (load_now) begin
            second_q <= xfer_second;
         end
      end
   end

   // Pin side: serial out, its enable, terminations
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sout_q <= 1'b0;
         oe_q <= 1'b0;
         term_q <= 1'b0;
      end else begin
         sout_q <= first_q[31];
         oe_q <= ser_s;
         term_q <= term_s;
      end
   end

   // Bus decode, word aligned
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
   assign wb_wr = wb_req & wb_we_i;
   assign ctrl_hit = {wb_adr_i[7:2], 2'b00} == `OFF_CTRL;
   assign first_hit = {wb_adr_i[7:2], 2'b00} == `OFF_FIRST;
   assign second_hit = {wb_adr_i[7:2], 2'b00} == `OFF_SECOND;
   assign stat_hit = {wb_adr_i[7:2], 2'b00} == `OFF_STAT;
   // Unmapped reads return zero
   assign rd_w = ctrl_hit ? {31'h0, ctrl_q}
      : first_hit ? first_q
      : second_hit ? second_q
      : stat_hit ? {22'h0, term_q, ser_s, en_q}
      : 32'h0;

   // Bus slave: one-cycle answer to every request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0;
         ctrl_q <= `CTRL_RST;
      end else begin
         wb_ack_q <= wb_req;
         wb_dat_q <= wb_req ? rd_w : 32'h0;
         if (wb_wr & ctrl_hit & wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[`CTRL_ACCEPT];
         end
      end
   end

   // Outputs straight from flops
   assign bit1_or_shift_output_o = sout_q;
   assign bit1_or_shift_output_oe_o = oe_q;
   assign buffer_enable_o = en_q;
   assign switch_code_o = second_q;
   assign termination_on_o = term_q;
   assign wb_dat_o = wb_dat_q;
   assign wb_ack_o = wb_ack_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Named steps of a write
   sequence s_taken_ser;
      ser_wr;
   endsequence
   sequence s_par_cmd(logic [3:0] c);
      par_wr && (cmd_w == c);
   endsequence

   property p_shift;
      s_taken_ser |=> first_q == {$past(first_q[30:0]), $past(d0_s)};
   endproperty
   a_shift: assert property (p_shift)
      else $error("serial shift wrong");

   property p_ignore;
      wr_rise && !cs_ok |=> $stable(first_q);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("write taken without chip select");

   property p_par_wr;
      par_store |=> (first_q & $past(nib_mask))
         == $past({8{cmd_w}} & nib_mask);
   endproperty
   a_par_wr: assert property (p_par_wr)
      else $error("parallel nibble not stored");

   property p_ctl_nowr;
      par_wr && class_s && (cmd_w != 4'h8) |=> $stable(first_q);
   endproperty
   a_ctl_nowr: assert property (p_ctl_nowr)
      else $error("control code stored in rank one");

   property p_edge;
      mode_s && lt_rise |=> second_q == $past(xfer_second);
   endproperty
   a_edge: assert property (p_edge)
      else $error("edge transfer missed");

   property p_hold;
      mode_s && !lt_rise && !par_wr |=> $stable(second_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("rank two changed without edge");

   property p_level;
      !mode_s && !lt_s ##1 !mode_s && !lt_s
         |-> second_q == $past(xfer_second);
   endproperty
   a_level: assert property (p_level)
      else $error("rank two not transparent");

   property p_ctl_load;
      par_ctl |=> second_q == $past(xfer_second);
   endproperty
   a_ctl_load: assert property (p_ctl_load)
      else $error("control code did not load rank two");

   property p_soft;
      par_sw |=> second_q == $past(xfer_second);
   endproperty
   a_soft: assert property (p_soft)
      else $error("software transfer missed");

   property p_off_one;
      s_par_cmd(4'hb) |=> !buffer_enable_o[$past(addr_s)];
   endproperty
   a_off_one: assert property (p_off_one)
      else $error("buffer not switched off");

   property p_on_all;
      s_par_cmd(4'he) |=> buffer_enable_o == 8'hff;
   endproperty
   a_on_all: assert property (p_on_all)
      else $error("buffers not all on");

   property p_ser_off;
      load_now && !par_ctl && (first_q[31:28] == 4'ha)
         |=> !buffer_enable_o[0] && (second_q[31:28] == 4'ha);
   endproperty
   a_ser_off: assert property (p_ser_off)
      else $error("serial off code not applied");

   property p_reset;
      $fell(rst_i) |-> buffer_enable_o == 8'h00;
   endproperty
   a_reset: assert property (p_reset)
      else $error("buffers enabled after reset");

   property p_sout;
      ser_s |=> bit1_or_shift_output_oe_o
         && (bit1_or_shift_output_o == $past(first_q[31]));
   endproperty
   a_sout: assert property (p_sout)
      else $error("serial output wrong");

   property p_term;
      ##1 termination_on_o == $past(term_s);
   endproperty
   a_term: assert property (p_term)
      else $error("termination not followed");
endmodule

// File: design/xpt_defs.svh
// Constants of the crosspoint switch control port.
// Assumes inclusion by bare name from the design module.
`ifndef XPT_DEFS_SVH
`define XPT_DEFS_SVH
// Positions inside the synchronised pin vector
`define POS_IFSEL 0
`define POS_D0 1
`define POS_D1 2
`define POS_D2 3
`define POS_CLASS 4
`define POS_ADDR 5
`define POS_WR 8
`define POS_LT 9
`define POS_CSN 10
`define POS_CS 11
`define POS_MODE 12
`define POS_TERM 13
`define PIN_W 14
// Register offsets on the bus
`define OFF_CTRL 8'h00
`define OFF_FIRST 8'h04
`define OFF_SECOND 8'h08
`define OFF_STAT 8'h0c
// Field positions
`define CTRL_ACCEPT 0
`define STAT_EN 0
`define STAT_SER 8
`define STAT_TERM 9
// Reset values
`define CTRL_RST 1'b1
`define FIRST_RST 32'h0000_0000
`define SECOND_RST 32'h0000_0000
`define EN_RST 8'h00
`endif

// File: design/xpt_types_pkg.sv
// Types shared by the crosspoint switch control port.
// Assumes nothing of its surroundings.
package xpt_types_pkg;
   // One four-bit command or selection code
   typedef logic [3:0] code_t;
   // Command codes above the channel numbers
   typedef enum logic [3:0] {
      CMD_GROUND = 4'h8,
      CMD_SER_ON = 4'h9,
      CMD_SER_OFF = 4'ha,
      CMD_OFF_ONE = 4'hb,
      CMD_ON_ONE = 4'hc,
      CMD_OFF_ALL = 4'hd,
      CMD_ON_ALL = 4'he,
      CMD_SW_XFER = 4'hf
   } cmd_e;
endpackage

// File: sim/crosspoint_switch_control_port_tb_top.sv
// Self-checking bench: pins via host model, registers via Wishbone.
// Assumes the design and host model files are compiled first.
`timescale 1ns/1ps
module crosspoint_switch_control_port_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we; // Bus request lines, idled at time zero
   logic [7:0] adr;
   logic [31:0] wdat, rd;
   logic [3:0] sel, sel_req; // Byte lanes driven, lanes for next call
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ifsel, d0, hd1, d1_o, d1_oe, d2, cls, wr, lt, csn, cs, mode, term;
   logic [2:0] osel;
   logic [7:0] buffer_enable_o;
   logic [31:0] switch_code_o;
   logic termination_on_o;
   wire d1_w = d1_oe ? d1_o : hd1; // Shared data bit one pin
   int num_errors = 0;
   int tests_run = 0;
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   host_ctrl_model host (.clk_i(clk_i), .ifsel_o(ifsel), .d0_o(d0),
      .d1_o(hd1), .d2_o(d2), .cls_o(cls), .adr_o(osel), .wr_o(wr),
      .lt_o(lt), .cs_n_o(csn), .cs_o(cs), .mode_o(mode), .term_o(term));
   crosspoint_switch_control_port DUT (.clk_i(clk_i), .rst_i(rst_i),
      .interface_select_i(ifsel), .bit0_or_shift_input_i(d0),
      .bit1_or_shift_output_i(d1_w), .bit1_or_shift_output_o(d1_o),
      .bit1_or_shift_output_oe_o(d1_oe), .data_bit_two_i(d2),
      .code_class_bit_i(cls), .output_select_i(osel),
      .write_strobe_i(wr), .transfer_strobe_i(lt),
      .chip_select_n_i(csn), .chip_select_i(cs),
      .transfer_mode_i(mode), .termination_enable_i(term),
      .buffer_enable_o(buffer_enable_o), .switch_code_o(switch_code_o),
      .termination_on_o(termination_on_o), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   // Compare one value, report and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, sel_req};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20) num_errors++;
      {cyc, stb, we} <= 3'b000;
   endtask
   // Print counts and verdict, end the run
   task automatic give_verdict();
      $display("errors=%0d comparisons=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #500000;
      num_errors++;
      give_verdict();
   end
   // Main sequence
   initial begin
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hf;
      sel_req = 4'hf;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      host.tick(4);
      chk({24'h0, buffer_enable_o}, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      sel_req = 4'he;
      wb(1'b1, 8'h00, 32'h0);
      sel_req = 4'hf;
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, 8'h00, 32'h1);
      host.par_cmd(3'd2, 4'h5);
      host.par_cmd(3'd5, 4'h8);
      chk(switch_code_o, 32'h0);
      host.latch();
      chk(switch_code_o, 32'h0050_0800);
      host.par_cmd(3'd2, 4'hc);
      chk({24'h0, buffer_enable_o}, 32'h04);
      host.par_cmd(3'd0, 4'he);
      chk({24'h0, buffer_enable_o}, 32'hff);
      host.par_cmd(3'd0, 4'hb);
      chk({24'h0, buffer_enable_o}, 32'hfe);
      host.par_cmd(3'd0, 4'hd);
      chk({24'h0, buffer_enable_o}, 32'h00);
      chk(switch_code_o, 32'h0050_0800);
      for (int k = 0; k < 2; k++) begin
         host.set_ctl({k[0], k[0], 4'h4});
         host.par_cmd(3'd1, 4'h3);
         wb(1'b0, 8'h04, 32'h0);
         chk(rd, 32'h0050_0800);
      end
      host.set_ctl(6'h24);
      host.set_ctl(6'h14);
      wb(1'b1, 8'h00, 32'h0);
      host.par_cmd(3'd1, 4'h3);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0050_0800);
      wb(1'b1, 8'h00, 32'h1);
      host.par_cmd(3'd4, 4'h9);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0050_0800);
      host.par_cmd(3'd1, 4'h3);
      chk(switch_code_o, 32'h0050_0800);
      host.par_cmd(3'd0, 4'hf);
      chk(switch_code_o, 32'h0350_0800);
      host.set_ctl(6'h10);
      host.par_cmd(3'd3, 4'h7);
      chk(switch_code_o, 32'h0357_0800);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0357_0800);
      host.set_ctl(6'h17);
      chk({31'h0, termination_on_o}, 32'h1);
      host.ser_frame(32'h8123_459a);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h8123_459a);
      chk({30'h0, d1_oe, d1_o}, 32'h3);
      host.latch();
      chk({24'h0, buffer_enable_o}, 32'h40);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0000_0340);
      chk(switch_code_o & 32'hffff_ff0f, 32'h8123_450a);
      host.set_ctl(6'h24);
      chk({31'h0, termination_on_o}, 32'h0);
      chk({31'h0, d1_oe}, 32'h0);
      rst_i <= 1'b1;
      host.tick(2);
      rst_i <= 1'b0;
      host.tick(1);
      chk({24'h0, buffer_enable_o}, 32'h0);
      give_verdict();
   end
endmodule

// File: sim/host_ctrl_model.sv
// Host controller model that drives the switch control pins.
// Assumes a free-running clk_i; pins change just after its rising edge.
`timescale 1ns/1ps
module host_ctrl_model (
   input wire logic clk_i,
   output logic ifsel_o,
   output logic d0_o,
   output logic d1_o,
   output logic d2_o,
   output logic cls_o,
   output logic [2:0] adr_o,
   output logic wr_o,
   output logic lt_o,
   output logic cs_n_o,
   output logic cs_o,
   output logic mode_o,
   output logic term_o
);
   // Idle: parallel, selected, edge mode, strobes low
   initial begin
      {ifsel_o, d0_o, d1_o, d2_o, cls_o, adr_o, wr_o, lt_o} = '0;
      {cs_n_o, cs_o, mode_o, term_o} = 4'h6;
   end
   // Wait a number of clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Static lines; latch level held for software transfer
   task automatic set_ctl(input logic [5:0] v);
      tick(1);
      {cs_n_o, cs_o} <= v[5:4];
      {mode_o, lt_o} <= v[3:2];
      ifsel_o <= v[1];
      term_o <= v[0];
      tick(4);
   endtask
   // One parallel word, 200 ns setup, 200 ns high
   task automatic par_cmd(input logic [2:0] a, input logic [3:0] c);
      tick(1);
      adr_o <= a;
      {cls_o, d2_o, d1_o, d0_o} <= c;
      tick(4);
      wr_o <= 1'b1;
      tick(4);
      wr_o <= 1'b0;
      tick(4);
   endtask
   // Serial frame, MSB first, 400 ns per bit
   task automatic ser_frame(input logic [31:0] f);
      tick(1);
      {cls_o, d2_o} <= 2'b11;
      for (int i = 31; i >= 0; i--) begin
         d0_o <= f[i];
         wr_o <= 1'b0;
         tick(4);
         wr_o <= 1'b1;
         tick(4);
      end
      wr_o <= 1'b0;
      d0_o <= ~f[0];
      tick(4);
   endtask
   // Transfer strobe pulse
   task automatic latch();
      tick(1);
      lt_o <= 1'b1;
      tick(4);
      lt_o <= 1'b0;
      tick(4);
   endtask
endmodule
